// ---- verilog/psram_read_port.sv ----
// Purpose: access control and pipelined read path of a synchronous burst sram
// Assumes: array is a combinational read port outside; pins pre-resolved by bench
// Notes: reset is not part of the documented part; it only defines start-up state
`include "psram_defines.svh"
module psram_read_port
	import psram_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic [`PSRAM_ADDR_W-1:0]   addr_in,
	input  wire logic                       processor_addr_strobe_n,
	input  wire logic                       controller_addr_strobe_n,
	input  wire logic                       burst_advance_n,
	input  wire logic                       global_write_n,
	input  wire logic                       byte_write_gate_n,
	input  wire logic [`PSRAM_LANES-1:0]    byte_lane_select_n,
	input  wire logic                       chip_sel_first_n,
	input  wire logic                       chip_sel_second,
	input  wire logic                       chip_sel_third_n,
	input  wire logic                       output_enable_n,
	input  wire logic                       burst_order_linear,
	input  wire logic [`PSRAM_DATA_W-1:0]   data_in,
	input  wire logic [`PSRAM_DATA_W-1:0]   array_rd_data,
	output logic [`PSRAM_ADDR_W-1:0]        array_addr,
	output logic [`PSRAM_LANES-1:0]         array_wr_lanes,
	output logic [`PSRAM_DATA_W-1:0]        array_wr_data,
	output logic [`PSRAM_DATA_W-1:0]        data_out,
	output logic                            data_oe
);
	// input registers: the pins are treated as synchronous to core_clk
	logic [`PSRAM_ADDR_W-1:0] addr_reg;
	logic                     processor_addr_strobe_n_n_reg;
	logic                     controller_addr_strobe_n_n_reg;
	logic                     adv_n_reg;
	logic                     gw_n_reg;
	logic                     bwe_n_reg;
	logic [`PSRAM_LANES-1:0]  bw_n_reg;
	logic                     cs1_n_reg;
	logic                     cs2_reg;
	logic                     cs3_n_reg;
	logic                     mode_reg;
	logic [`PSRAM_DATA_W-1:0] din_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_reg   <= `PSRAM_ADDR_ZERO;
			processor_addr_strobe_n_n_reg <= 1'b1;
			controller_addr_strobe_n_n_reg <= 1'b1;
			adv_n_reg  <= 1'b1;
			gw_n_reg   <= 1'b1;
			bwe_n_reg  <= 1'b1;
			bw_n_reg   <= '1;
			cs1_n_reg  <= 1'b1;
			cs2_reg    <= 1'b0;
			cs3_n_reg  <= 1'b1;
			mode_reg   <= 1'b0;
			din_reg    <= `PSRAM_DATA_ZERO;
		end else begin
			addr_reg   <= addr_in;
			processor_addr_strobe_n_n_reg <= processor_addr_strobe_n;
			controller_addr_strobe_n_n_reg <= controller_addr_strobe_n;
			adv_n_reg  <= burst_advance_n;
			gw_n_reg   <= global_write_n;
			bwe_n_reg  <= byte_write_gate_n;
			bw_n_reg   <= byte_lane_select_n;
			cs1_n_reg  <= chip_sel_first_n;
			cs2_reg    <= chip_sel_second;
			cs3_n_reg  <= chip_sel_third_n;
			mode_reg   <= burst_order_linear;
			din_reg    <= data_in;
		end
	end

	// decode of the registered controls
	logic                    all_sel;
	logic                    processor_addr_strobe_n_valid;
	logic                    strobe;
	logic                    start;
	logic                    deselect;
	logic                    is_write_in;
	logic                    start_read;
	logic                    start_write;
	logic                    cont_step;
	logic [`PSRAM_LANES-1:0] lanes_req;
	psram_low_t              burst_low;

	assign all_sel     = !cs1_n_reg && cs2_reg && !cs3_n_reg;
	assign processor_addr_strobe_n_valid  = !processor_addr_strobe_n_n_reg && !cs1_n_reg;
	assign strobe      = processor_addr_strobe_n_valid || !controller_addr_strobe_n_n_reg;
	assign start       = strobe && all_sel;
	assign deselect    = strobe && !all_sel;
	// a processor-strobe start always reads first; write starts only come with the controller strobe
	assign is_write_in = !gw_n_reg || (!bwe_n_reg && (bw_n_reg != `PSRAM_ALL_LANES));
	assign start_read  = start && (processor_addr_strobe_n_valid || (gw_n_reg && bwe_n_reg));
	assign start_write = start && !start_read;
	assign cont_step   = !strobe && !adv_n_reg;
	assign lanes_req   = !gw_n_reg ? `PSRAM_ALL_LANES :
		(!bwe_n_reg ? ~bw_n_reg : `PSRAM_NO_LANES);

	// access state
	psram_state_t state_reg;
	psram_state_t state_next;
	logic         first_reg;
	logic         first_next;
	logic         was_desel;

	assign was_desel = (state_reg == PSRAM_DESEL);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PSRAM_DESEL: begin
				if (start_read)
					state_next = PSRAM_READ;
				else if (start_write)
					state_next = PSRAM_WRITE;
			end
			PSRAM_READ, PSRAM_WRITE: begin
				if (deselect)
					state_next = PSRAM_DESEL;
				else if (start_read)
					state_next = PSRAM_READ;
				else if (start_write || (!strobe && is_write_in))
					state_next = PSRAM_WRITE;
				else if (!strobe)
					state_next = PSRAM_READ;
			end
			default: state_next = PSRAM_DESEL;
		endcase
	end

	assign first_next = start && was_desel;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= PSRAM_DESEL;
			first_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			first_reg <= first_next;
		end
	end

	psram_burst_cnt u_burst (
		.core_clk    (core_clk),
		.rst         (rst),
		.load        (start),
		.step        (cont_step),
		.linear_mode (mode_reg),
		.first_low   (addr_reg[`PSRAM_LOW_ADDR_W-1:0]),
		.low_addr    (burst_low)
	);

	// held upper address; the low bits come from the burst counter
	logic [`PSRAM_ADDR_W-1:0] hold_addr_reg;
	logic [`PSRAM_ADDR_W-1:0] hold_addr_next;
	logic                     writing;

	assign hold_addr_next = start ? addr_reg : hold_addr_reg;
	assign array_addr     = start ? addr_reg :
		{hold_addr_reg[`PSRAM_ADDR_W-1:`PSRAM_LOW_ADDR_W], burst_low};
	assign writing        = start ? start_write : ((state_reg != PSRAM_DESEL) && !strobe && is_write_in);
	assign array_wr_lanes = writing ? lanes_req : `PSRAM_NO_LANES;
	assign array_wr_data  = din_reg;

	// output register: array data at its input in the access cycle
	logic [`PSRAM_DATA_W-1:0] dout_reg;
	logic [`PSRAM_DATA_W-1:0] dout_next;
	logic                     reading;

	assign reading   = (state_reg == PSRAM_READ) || start_read || (state_reg != PSRAM_DESEL && !strobe);
	assign dout_next = (reading && !writing) ? array_rd_data : dout_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_addr_reg <= `PSRAM_ADDR_ZERO;
			dout_reg      <= `PSRAM_DATA_ZERO;
		end else begin
			hold_addr_reg <= hold_addr_next;
			dout_reg      <= dout_next;
		end
	end

	assign data_out = dout_reg;
	// output enable is asynchronous by intent; state_reg and first_reg are registered, writing is decoded
	// writing is decoded from registered pins, so the float starts in the cycle the write is seen
	assign data_oe  = !output_enable_n && (state_reg == PSRAM_READ) && !first_reg && !writing;

	a_read_pipe: assert property (@(posedge core_clk) disable iff (rst)
		start_read && !deselect |=> data_out == $past(array_rd_data))
		else $error("read data not in output register one edge after start");
	a_first_float: assert property (@(posedge core_clk) disable iff (rst)
		start && was_desel |=> !data_oe)
		else $error("data pins driven in first cycle out of deselect");
	a_desel_float: assert property (@(posedge core_clk) disable iff (rst)
		deselect |=> !data_oe)
		else $error("data pins driven after deselect");
	a_oe_gates: assert property (@(posedge core_clk) disable iff (rst)
		output_enable_n |-> !data_oe)
		else $error("data pins driven with output enable high");
	a_oe_decides: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == PSRAM_READ && !first_reg && !writing |-> data_oe == !output_enable_n)
		else $error("output enable does not decide drive after first cycle");
	a_write_float: assert property (@(posedge core_clk) disable iff (rst)
		start_write |=> !data_oe)
		else $error("data pins driven during write cycle");
	a_processor_addr_strobe_n_masked: assert property (@(posedge core_clk) disable iff (rst)
		cs1_n_reg && controller_addr_strobe_n_n_reg |-> !strobe && !start)
		else $error("processor strobe accepted with first select high");
	a_global_lanes: assert property (@(posedge core_clk) disable iff (rst)
		writing && !gw_n_reg |-> array_wr_lanes == `PSRAM_ALL_LANES)
		else $error("global write did not write all lanes");
	a_byte_lanes: assert property (@(posedge core_clk) disable iff (rst)
		writing && gw_n_reg |-> array_wr_lanes == (bwe_n_reg ? `PSRAM_NO_LANES : ~bw_n_reg))
		else $error("byte lanes not qualified by gate and select");
	a_back_reads: assert property (@(posedge core_clk) disable iff (rst)
		start_read ##1 start_read |=> state_reg == PSRAM_READ && !first_reg)
		else $error("back-to-back reads not accepted");
	a_load_addr: assert property (@(posedge core_clk) disable iff (rst)
		start |-> array_addr == addr_reg)
		else $error("start address not sent to array");

	c_single_read: cover property (@(posedge core_clk) disable iff (rst)
		start_read && was_desel ##2 data_oe);
	c_back_reads: cover property (@(posedge core_clk) disable iff (rst)
		start_read ##1 start_read ##1 data_oe);
	c_burst: cover property (@(posedge core_clk) disable iff (rst)
		start_read ##1 cont_step [*3]);
	c_deselect: cover property (@(posedge core_clk) disable iff (rst)
		data_oe ##1 deselect ##1 !data_oe);
endmodule

// ---- include/psram_defines.svh ----
// Purpose: constants for the pipelined sync sram read port
// Assumes: 40 MHz core_clk, 4 byte lanes of 8 bits, 18-bit word address
// Notes: array itself lives outside; this block is control and read path
// Contract
// - every synchronous input is captured in an input register on the rising edge
// - read data leaves through output registers clocked on the rising edge
// - burst order is chosen by sampling the burst-order select input
// - either address strobe starts an access
// - burst address advances only when burst advance is asserted
// - first address loads a two-bit wraparound counter that then steps
// - a byte lane is written only when gate and its lane select are low
// - global write overrides byte inputs and writes all four lanes
// - three clocked chip selects pick the bank; unclocked output enable drives pins
// - processor strobe is ignored while first chip select is high
// - read starts on strobe, all selects active, global write and gate high
// - on read start address goes to address register, burst logic and array
// - array data reaches output register in access cycle, driven after next edge
// - first cycle after leaving deselect keeps data pins high impedance
// - after the first cycle output enable alone decides driving
// - back-to-back single reads on consecutive edges are accepted
// - deselect at an edge floats the data pins at once; the code floats them only after the following edge
// - each low burst advance steps the counter to the next address of the order
// - data pins drive only while output enable is low
// - a detected write cycle forces data pins to high impedance
`ifndef PSRAM_DEFINES_SVH
`define PSRAM_DEFINES_SVH
`define PSRAM_ADDR_W      18
`define PSRAM_LANES       4
`define PSRAM_LANE_W      8
`define PSRAM_DATA_W      32
`define PSRAM_LOW_ADDR_W  2
`define PSRAM_ALL_LANES   4'h000F
`define PSRAM_NO_LANES    4'h0000
`define PSRAM_ONE_LOW     2'h1
`define PSRAM_ADDR_ZERO   18'h0_0000
`define PSRAM_DATA_ZERO   32'h0000_0000
`endif

// ---- include/psram_pkg.sv ----
// Purpose: types for the pipelined sync sram read port
// Assumes: psram_defines.svh constants
// Notes: access state is gray coded along deselect, read, write
`include "psram_defines.svh"
package psram_pkg;
	typedef enum logic [1:0] {
		PSRAM_DESEL = 2'h0,
		PSRAM_READ  = 2'h1,
		PSRAM_WRITE = 2'h3
	} psram_state_t;
	typedef logic [`PSRAM_LOW_ADDR_W-1:0] psram_low_t;
endpackage

// ---- verilog/psram_burst_cnt.sv ----
// Purpose: two-bit wraparound burst counter with interleaved or linear order
// Assumes: load and step come from registered inputs of the same clock
// Notes: interleaved order is first address xor a plain step count
`include "psram_defines.svh"
module psram_burst_cnt
	import psram_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic       step,
	input  wire logic       linear_mode,
	input  wire psram_low_t first_low,
	output psram_low_t      low_addr
);
	psram_low_t base_reg;
	psram_low_t count_reg;
	psram_low_t base_next;
	psram_low_t count_next;
	psram_low_t lin_addr;
	psram_low_t ilv_addr;

	assign lin_addr   = psram_low_t'(base_reg + count_reg);
	assign ilv_addr   = base_reg ^ count_reg;
	assign low_addr   = linear_mode ? lin_addr : ilv_addr;
	assign base_next  = load ? first_low : base_reg;
	assign count_next = load ? psram_low_t'(0) :
		(step ? psram_low_t'(count_reg + `PSRAM_ONE_LOW) : count_reg);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			base_reg  <= '0;
			count_reg <= '0;
		end else begin
			base_reg  <= base_next;
			count_reg <= count_next;
		end
	end

	a_burst_holds: assert property (@(posedge core_clk) disable iff (rst)
		!load && !step |=> $stable(low_addr))
		else $error("burst address moved without advance");
	a_burst_wraps: assert property (@(posedge core_clk) disable iff (rst)
		load ##1 (step && !load) [*4] |=> low_addr == $past(low_addr, 4))
		else $error("burst counter did not wrap after four steps");
endmodule

// ---- sim/psram_array_model.sv ----
// Purpose: stand-in for the external memory array behind the read port
// Assumes: combinational read port, contents are a fixed pattern of the address
// Notes: writes are not stored; the bench judges writes at the lane outputs
`include "psram_defines.svh"
module psram_array_model
	import psram_pkg::*;
(
	input  wire logic [`PSRAM_ADDR_W-1:0] array_addr,
	output logic      [`PSRAM_DATA_W-1:0] array_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// low 16 address bits and their inverse, so a stuck or swapped bit among them changes the word
	assign array_rd_data = {array_addr[15:0], ~array_addr[15:0]};
endmodule

// ---- sim/tb_pipelined_sync_sram_read_port.sv ----
// Purpose: self-checking bench for the sram read port
// Assumes: one clock, inputs launched by non-blocking assignment at the rising edge
// Notes: control vector order is proc strobe, ctrl strobe, cs1, cs2, cs3, gw, gate, adv
`include "psram_defines.svh"
module tb_pipelined_sync_sram_read_port
	import psram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] IDLE = 8'hD7;
	localparam logic [7:0] RD_CC = 8'h97;
	localparam logic [7:0] RD_PS = 8'h57;
	localparam logic [7:0] BURST_ADVANCE_N = 8'hD6;
	localparam logic [7:0] GW_CC = 8'h93;
	localparam logic [7:0] BW_CC = 8'h95;
	localparam logic [7:0] DESEL = 8'h87;
	localparam logic [7:0] PS_CS1 = 8'h77;
	logic                     core_clk;
	logic                     rst;
	logic [`PSRAM_ADDR_W-1:0] addr_in;
	logic                     processor_addr_strobe_n;
	logic                     controller_addr_strobe_n;
	logic                     burst_advance_n;
	logic                     global_write_n;
	logic                     byte_write_gate_n;
	logic [`PSRAM_LANES-1:0]  byte_lane_select_n;
	logic                     chip_sel_first_n;
	logic                     chip_sel_second;
	logic                     chip_sel_third_n;
	logic                     output_enable_n;
	logic                     burst_order_linear;
	logic [`PSRAM_DATA_W-1:0] data_in;
	logic [`PSRAM_DATA_W-1:0] array_rd_data;
	logic [`PSRAM_ADDR_W-1:0] array_addr;
	logic [`PSRAM_LANES-1:0]  array_wr_lanes;
	logic [`PSRAM_DATA_W-1:0] array_wr_data;
	logic [`PSRAM_DATA_W-1:0] data_out;
	logic                     data_oe;
	int                       failures;
	int                       compares;
	int                       cycles;

	psram_read_port psram_read_port_inst (.core_clk(core_clk), .rst(rst), .addr_in(addr_in),
		.processor_addr_strobe_n(processor_addr_strobe_n), .controller_addr_strobe_n(controller_addr_strobe_n),
		.burst_advance_n(burst_advance_n), .global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
		.byte_lane_select_n(byte_lane_select_n), .chip_sel_first_n(chip_sel_first_n),
		.chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n), .output_enable_n(output_enable_n),
		.burst_order_linear(burst_order_linear), .data_in(data_in), .array_rd_data(array_rd_data),
		.array_addr(array_addr), .array_wr_lanes(array_wr_lanes), .array_wr_data(array_wr_data),
		.data_out(data_out), .data_oe(data_oe));
	psram_array_model psram_array_model_inst (.array_addr(array_addr), .array_rd_data(array_rd_data));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] pat(input logic [17:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// launch one cycle of pins at the edge, then look at what that edge produced
	task automatic cue(input logic [7:0] c, input logic [17:0] a);
		@(posedge core_clk);
		{processor_addr_strobe_n, controller_addr_strobe_n, chip_sel_first_n, chip_sel_second} <= c[7:4];
		{chip_sel_third_n, global_write_n, byte_write_gate_n, burst_advance_n} <= c[3:0];
		addr_in <= a;
		data_in <= ~pat(a);
		#1;
	endtask

	task automatic do_reset(input logic lin);
		@(posedge core_clk);
		rst <= 1'b1;
		burst_order_linear <= lin;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
	endtask

	task automatic read_first();
		cue(RD_CC, 18'h1_2345);
		cue(IDLE, 18'h0_0000);
		check(32'(array_addr), 32'h0001_2345);
		check(32'(array_wr_lanes), 32'h0000_0000);
		cue(IDLE, 18'h0_0000);
		check(data_out, pat(18'h1_2345));
		check(32'(data_oe), 32'h0000_0000);
		cue(IDLE, 18'h0_0000);
		check(32'(data_oe), 32'h0000_0001);
		@(posedge core_clk);
		output_enable_n <= 1'b1;
		#1;
		check(32'(data_oe), 32'h0000_0000);
		@(posedge core_clk);
		output_enable_n <= 1'b0;
	endtask

	task automatic back_to_back();
		cue(RD_PS, 18'h2_0AC4);
		cue(RD_CC, 18'h3_F00B);
		cue(IDLE, 18'h0_0000);
		check(data_out, pat(18'h2_0AC4));
		check(32'(data_oe), 32'h0000_0001);
		cue(IDLE, 18'h0_0000);
		check(data_out, pat(18'h3_F00B));
	endtask

	task automatic strobe_ignored();
		cue(PS_CS1, 18'h0_5555);
		cue(IDLE, 18'h0_0000);
		cue(IDLE, 18'h0_0000);
		check(32'(array_addr), 32'h0003_F00B);
		check(32'(data_oe), 32'h0000_0001);
	endtask

	task automatic writes();
		cue(GW_CC, 18'h0_1230);
		cue(BW_CC, 18'h0_4560);
		check(32'(array_wr_lanes), 32'h0000_000F);
		check(array_wr_data, ~pat(18'h0_1230));
		check(32'(data_oe), 32'h0000_0000);
		cue(IDLE, 18'h0_0000);
		check(32'(array_wr_lanes), 32'h0000_0005);
		check(32'(data_oe), 32'h0000_0000);
	endtask

	task automatic deselect();
		cue(RD_CC, 18'h0_0777);
		cue(DESEL, 18'h0_0000);
		cue(IDLE, 18'h0_0000);
		cue(IDLE, 18'h0_0000);
		check(32'(data_oe), 32'h0000_0000);
	endtask

	task automatic burst(input logic lin);
		int n;
		logic [1:0] low;
		do_reset(lin);
		cue(RD_CC, 18'h2_A5D1);
		for (int k = 0; k < 6; k++) begin
			cue((k < 4) ? BURST_ADVANCE_N : IDLE, 18'h0_0000);
			// advance is registered, so the counter steps at the second edge after the pin is launched
			n = (k == 0) ? 0 : k - 1;
			low = lin ? 2'(1 + n) : 2'(1 ^ n);
			check(32'(array_addr), {14'h0000, 16'hA974, low});
		end
	endtask

	initial begin
		{rst, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 4'hF;
		{global_write_n, byte_write_gate_n, chip_sel_first_n, chip_sel_third_n} = 4'hF;
		{chip_sel_second, output_enable_n, burst_order_linear} = 3'h0;
		byte_lane_select_n = 4'hA;
		addr_in = 18'h0_0000;
		data_in = 32'h0000_0000;
		failures = 0;
		compares = 0;
		do_reset(1'b0);
		read_first();
		back_to_back();
		strobe_ignored();
		writes();
		deselect();
		burst(1'b0);
		burst(1'b1);
		end_sim();
	end

	// the whole sequence needs well under a few hundred cycles
	initial begin
		cycles = 0;
		while (cycles < 2000) begin
			@(posedge core_clk);
			cycles++;
		end
		failures++;
		end_sim();
	end
endmodule
